/* File: tfac_comparator.sv */
// timing frame action comparator: last per-flow comparator stage
// assumes upstream stages present the header bytes, prior match and
// frame values in one cycle on the same clock; rewriter consumes outputs
`timescale 1ns/1ps
`include "tfac_params.svh"
module tfac_comparator (
    input  wire logic                       mclk_in,         // 250 MHz clock
    input  wire logic                       sys_rst_in,      // sync reset, high
    input  wire logic [`TFAC_AW-1:0]        avs_address_in,  // byte address
    input  wire logic                       avs_read_in,     // read request
    input  wire logic                       avs_write_in,    // write request
    input  wire logic [31:0]                avs_writedata_in,// write data
    input  wire logic [3:0]                 avs_byteenable_in,// byte lanes
    output logic [31:0]                     avs_readdata_out,// read data
    output logic                            avs_waitrequest_out,// stall
    input  wire logic                       hdr_valid_in,    // header present
    input  wire logic [8*`TFAC_HDR_BYTES-1:0] hdr_in,        // byte k at 8k
    input  wire logic [`TFAC_FLOWS-1:0]     prior_match_in,  // upstream hits
    input  wire logic                       egress_in,       // egress port
    input  wire logic [63:0]                cur_cf_in,       // frame correction
    input  wire logic [63:0]                stored_time_in,  // storage field
    input  wire logic [63:0]                local_time_in,   // captured time
    input  wire logic [63:0]                local_ns_in,     // time in ns
    input  wire logic [63:0]                latency_in,      // local latency
    input  wire logic [63:0]                path_delay_in,   // path delay
    output tfac_pkg::tfac_action_s          action_out,      // rewriter action
    output tfac_pkg::tfac_values_s          values_out,      // new field values
    output logic                            fifo_push_out,   // push timestamp
    output logic [63:0]                     fifo_time_out    // pushed time
);
    localparam int NF = `TFAC_FLOWS;

    logic [31:0]        mask_lo_q;
    logic [31:0]        mask_hi_q;
    logic [31:0]        asym_q;
    logic [31:0]        pat_lo_q [NF];
    logic [31:0]        pat_hi_q [NF];
    logic [31:0]        rng_q    [NF];
    logic [31:0]        act_q    [NF];
    logic [31:0]        loc_q    [NF];
    logic               wait_q;
    logic [31:0]        rdata_q;
    logic [15:0]        hits_q;
    tfac_pkg::tfac_action_s act_o_q;
    tfac_pkg::tfac_values_s val_o_q;
    logic               push_q;
    logic [63:0]        push_t_q;

    // bus decode
    wire                req       = avs_read_in | avs_write_in;
    wire                take      = req & ~wait_q;
    wire                wr_go     = avs_write_in & take;
    wire [3:0]          fsel      = avs_address_in[8:5];
    wire [2:0]          wsel      = avs_address_in[4:2];
    wire                in_flows  = (fsel >= `TFAC_FLOW_FIRST) &&
                                    (fsel <= `TFAC_FLOW_LAST);
    wire [3:0]          fsub      = fsel - `TFAC_FLOW_FIRST;
    wire [`TFAC_FW-1:0] fidx      = fsub[`TFAC_FW-1:0];
    wire [31:0]         bmask     = {{8{avs_byteenable_in[3]}},
                                     {8{avs_byteenable_in[2]}},
                                     {8{avs_byteenable_in[1]}},
                                     {8{avs_byteenable_in[0]}}};

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [31:0] m);
        merge = (old_v & ~m) | (new_v & m);
    endfunction

    wire [31:0] flow_rd = (wsel == `TFAC_W_PAT_LO) ? pat_lo_q[fidx] :
                          (wsel == `TFAC_W_PAT_HI) ? pat_hi_q[fidx] :
                          (wsel == `TFAC_W_RANGE)  ? rng_q[fidx]    :
                          (wsel == `TFAC_W_ACTION) ? act_q[fidx]    :
                          (wsel == `TFAC_W_LOC)    ? loc_q[fidx]    :
                          32'h0000_0000;
    // status mirrors this cycle's output register; only the hit count persists
    wire [31:0] stat_rd = {hits_q, 1'b0, act_o_q.flow, 3'h0, act_o_q.hit,
                           4'h0, act_o_q.cmd};

    logic [31:0] rd_d;
    always_comb begin
        if (avs_address_in == `TFAC_OFS_MASK_LO) begin
            rd_d = mask_lo_q;
        end else if (avs_address_in == `TFAC_OFS_MASK_HI) begin
            rd_d = mask_hi_q;
        end else if (avs_address_in == `TFAC_OFS_ASYM) begin
            rd_d = asym_q;
        end else if (avs_address_in == `TFAC_OFS_STAT) begin
            rd_d = stat_rd;
        end else if (in_flows) begin
            rd_d = flow_rd;
        end else begin
            rd_d = 32'h0000_0000;
        end
    end

    // one wait cycle: the answer lands on the second edge of a request
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else begin
            wait_q  <= ~(req & wait_q);
            if (avs_read_in & wait_q) begin
                rdata_q <= rd_d;
            end
        end
    end

    wire sel_mlo  = wr_go && (avs_address_in == `TFAC_OFS_MASK_LO);
    wire sel_mhi  = wr_go && (avs_address_in == `TFAC_OFS_MASK_HI);
    wire sel_asym = wr_go && (avs_address_in == `TFAC_OFS_ASYM);
    wire sel_flow = wr_go && in_flows;

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            mask_lo_q <= `TFAC_RST_WORD;
            mask_hi_q <= `TFAC_RST_WORD;
            asym_q    <= `TFAC_RST_WORD;
        end else begin
            if (sel_mlo) mask_lo_q <= merge(mask_lo_q, avs_writedata_in, bmask);
            if (sel_mhi) mask_hi_q <= merge(mask_hi_q, avs_writedata_in, bmask);
            if (sel_asym) asym_q <= merge(asym_q, avs_writedata_in, bmask);
        end
    end

    // per-flow settings, one copy per flow
    for (genvar f = 0; f < NF; f++) begin : g_regs
        wire hit_f = sel_flow && (int'(fidx) == f);
        always_ff @(posedge mclk_in) begin
            if (sys_rst_in) begin
                pat_lo_q[f] <= `TFAC_RST_WORD;
                pat_hi_q[f] <= `TFAC_RST_WORD;
                rng_q[f]    <= `TFAC_RST_WORD;
                act_q[f]    <= `TFAC_RST_WORD;
                loc_q[f]    <= `TFAC_RST_WORD;
            end else if (hit_f) begin
                if (wsel == `TFAC_W_PAT_LO)
                    pat_lo_q[f] <= merge(pat_lo_q[f], avs_writedata_in, bmask);
                if (wsel == `TFAC_W_PAT_HI)
                    pat_hi_q[f] <= merge(pat_hi_q[f], avs_writedata_in, bmask);
                if (wsel == `TFAC_W_RANGE)
                    rng_q[f] <= merge(rng_q[f], avs_writedata_in, bmask);
                if (wsel == `TFAC_W_ACTION)
                    act_q[f] <= merge(act_q[f], avs_writedata_in, bmask);
                if (wsel == `TFAC_W_LOC)
                    loc_q[f] <= merge(loc_q[f], avs_writedata_in, bmask);
            end
        end
    end

    // header bytes; vlan and label depth is resolved upstream, so any
    // encapsulation reaches this stage already aligned to the header
    logic [7:0]  hdr_b [`TFAC_HDR_BYTES];
    logic [63:0] head64;
    for (genvar k = 0; k < `TFAC_HDR_BYTES; k++) begin : g_bytes
        assign hdr_b[k] = hdr_in[8*k +: 8];
    end
    for (genvar k = 0; k < 8; k++) begin : g_head
        assign head64[63-8*k -: 8] = hdr_b[k];
    end
    wire [63:0] mask64 = {mask_hi_q, mask_lo_q};

    logic [NF-1:0] flow_hit;
    for (genvar f = 0; f < NF; f++) begin : g_match
        wire [63:0] pat   = {pat_hi_q[f], pat_lo_q[f]};
        wire        pm    = ((head64 ^ pat) & mask64) == 64'h0;
        wire [7:0]  rb    = hdr_b[rng_q[f][`TFAC_RNG_OFS]];
        wire        in_rg = (rb >= rng_q[f][`TFAC_RNG_LO]) &&
                            (rb <= rng_q[f][`TFAC_RNG_HI]);
        wire        rg_ok = ~rng_q[f][`TFAC_RNG_EN] | in_rg;
        assign flow_hit[f] = act_q[f][`TFAC_ACT_FLOWEN] & prior_match_in[f] &
                             pm & rg_ok;
    end

    // lowest flow index wins when several flows match
    logic [`TFAC_FW-1:0] win;
    always_comb begin
        win = '0;
        for (int f = NF - 1; f >= 0; f--) begin
            if (flow_hit[f]) win = f[`TFAC_FW-1:0];
        end
    end
    wire        any_hit = hdr_valid_in & (|flow_hit);
    wire [31:0] wa      = act_q[win];
    wire [31:0] wl      = loc_q[win];
    wire [3:0]  wcmd    = wa[`TFAC_ACT_CMD];
    wire [63:0] asym64  = {{32{asym_q[31]}}, asym_q};

    logic [63:0] cf_d;
    logic [63:0] ts_d;
    logic [63:0] nf_d;
    logic [63:0] act_ts_d;
    logic        cf_wr_d;
    logic        ts_wr_d;
    logic        nf_wr_d;
    always_comb begin
        cf_d     = cur_cf_in;
        ts_d     = stored_time_in;
        nf_d     = 64'h0;
        act_ts_d = 64'h0;
        cf_wr_d  = 1'b0;
        ts_wr_d  = 1'b0;
        nf_wr_d  = 1'b0;
        case (wcmd)
            tfac_pkg::cmd_cf_minus_time: begin
                cf_d = cur_cf_in - local_time_in;
                cf_wr_d = 1'b1;
            end
            tfac_pkg::cmd_cf_minus_latency_plus_path: begin
                cf_d = cur_cf_in - latency_in + path_delay_in;
                cf_wr_d = 1'b1;
            end
            tfac_pkg::cmd_cf_plus_time: begin
                cf_d = cur_cf_in + local_time_in;
                cf_wr_d = 1'b1;
            end
            tfac_pkg::cmd_cf_time_latency_storage: begin
                cf_d = cur_cf_in + local_time_in + latency_in - stored_time_in;
                cf_wr_d = 1'b1;
            end
            tfac_pkg::cmd_store_time: begin
                ts_d = local_time_in;
                ts_wr_d = 1'b1;
            end
            tfac_pkg::cmd_store_time_path_legacy: begin
                act_ts_d = local_time_in;
                ts_d = path_delay_in;
                cf_d = path_delay_in;
                ts_wr_d = 1'b1;
                cf_wr_d = 1'b1;
            end
            tfac_pkg::cmd_store_nanoseconds: begin
                nf_d = local_ns_in;
                nf_wr_d = 1'b1;
            end
            tfac_pkg::cmd_store_nanoseconds_peer: begin
                nf_d = local_ns_in + path_delay_in;
                cf_d = local_ns_in + path_delay_in;
                nf_wr_d = 1'b1;
                cf_wr_d = 1'b1;
            end
            default: begin
                cf_d = cur_cf_in;
            end
        endcase
    end

    // asymmetry rides on any modifying command; idle stays untouched
    wire        mod_cmd  = (wcmd != tfac_pkg::cmd_idle) &&
                           (wcmd <= tfac_pkg::cmd_store_nanoseconds_peer);
    wire        as_add   = mod_cmd & wa[`TFAC_ACT_ASADD];
    wire        as_sub   = mod_cmd & wa[`TFAC_ACT_ASSUB];
    wire [63:0] cf_a1    = as_add ? cf_d + asym64 : cf_d;
    wire [63:0] cf_fin   = as_sub ? cf_a1 - asym64 : cf_a1;
    wire [3:0]  zlen     = wl[`TFAC_LOC_ZLEN];

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            act_o_q  <= '0;
            val_o_q  <= '0;
            push_q   <= 1'b0;
            push_t_q <= 64'h0;
            hits_q   <= 16'h0000;
        end else begin
            act_o_q.valid    <= hdr_valid_in;
            act_o_q.hit      <= any_hit;
            act_o_q.flow     <= win;
            act_o_q.cmd      <= any_hit ? wcmd : 4'h0;
            act_o_q.cf_wr    <= any_hit & (cf_wr_d | as_add | as_sub);
            act_o_q.ts_wr    <= any_hit & ts_wr_d;
            act_o_q.nf_wr    <= any_hit & nf_wr_d;
            act_o_q.cf_loc   <= wl[`TFAC_LOC_CF];
            act_o_q.ts_loc   <= wl[`TFAC_LOC_TS];
            act_o_q.zero_loc <= wl[`TFAC_LOC_ZOFS];
            act_o_q.zero_len <= zlen;
            act_o_q.zero_en  <= any_hit & (zlen != 4'h0);
            val_o_q.cf        <= cf_fin;
            val_o_q.ts        <= ts_d;
            val_o_q.nf        <= nf_d;
            val_o_q.active_ts <= act_ts_d;
            push_q   <= any_hit & wa[`TFAC_ACT_SAVE] & egress_in;
            push_t_q <= local_time_in;
            if (any_hit) hits_q <= hits_q + 16'h0001;
        end
    end

    assign avs_readdata_out    = rdata_q;
    assign avs_waitrequest_out = wait_q;
    assign action_out          = act_o_q;
    assign values_out          = val_o_q;
    assign fifo_push_out       = push_q;
    assign fifo_time_out       = push_t_q;

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);

    // checks restate the rules on the ports rather than echo the case above
    idle_no_mod_a: assert property (
        action_out.valid && action_out.cmd == 4'h0 |->
        !action_out.cf_wr && !action_out.ts_wr && !action_out.nf_wr)
        else $error("idle command modified a field");
    miss_pass_a: assert property (
        action_out.valid && !action_out.hit |->
        !action_out.cf_wr && !action_out.ts_wr && !action_out.zero_en)
        else $error("unmatched frame was modified");
    cf_minus_a: assert property (
        any_hit && wcmd == 4'h1 && !as_add && !as_sub |=>
        values_out.cf == $past(cur_cf_in) - $past(local_time_in))
        else $error("code 1 correction wrong");
    cf_plus_a: assert property (
        any_hit && wcmd == 4'h3 && !as_add && !as_sub |=>
        values_out.cf == $past(cur_cf_in) + $past(local_time_in))
        else $error("code 3 correction wrong");
    push_egress_a: assert property (
        fifo_push_out |->
        $past(egress_in) && $past(any_hit) && fifo_time_out == $past(local_time_in))
        else $error("timestamp pushed without egress hit");
    ingress_push_a: assert property (
        !egress_in |=>
        !fifo_push_out)
        else $error("timestamp pushed on ingress");
    zero_gate_a: assert property (
        action_out.hit |->
        action_out.zero_en == (action_out.zero_len != 4'h0))
        else $error("clear enable disagrees with count");
    flow_enable_a: assert property (
        hdr_valid_in && !act_q[0][`TFAC_ACT_FLOWEN] |=>
        !(action_out.hit && action_out.flow == 3'd0))
        else $error("disabled flow matched");
    ts_store_a: assert property (
        any_hit && wcmd == 4'h5 |=>
        action_out.ts_wr && values_out.ts == $past(local_time_in))
        else $error("code 5 storage value wrong");
    legacy_store_a: assert property (
        any_hit && wcmd == 4'h6 |=>
        values_out.active_ts == $past(local_time_in) && values_out.ts == $past(path_delay_in))
        else $error("code 6 values wrong");
    nf_store_a: assert property (
        any_hit && wcmd == 4'h7 |=>
        action_out.nf_wr && values_out.nf == $past(local_ns_in))
        else $error("code 7 new field wrong");
    asym_add_a: assert property (
        any_hit && wcmd == 4'h4 && as_add && !as_sub |=>
        values_out.cf == $past(cur_cf_in) + $past(local_time_in) + $past(latency_in)
                         - $past(stored_time_in) + $past(asym64))
        else $error("asymmetry not added");
    asym_sub_a: assert property (
        any_hit && wcmd == 4'h8 && as_sub && !as_add |=>
        values_out.cf == $past(local_ns_in) + $past(path_delay_in) - $past(asym64))
        else $error("asymmetry not subtracted");
    bus_answer_a: assert property (
        avs_read_in && avs_waitrequest_out |=>
        !avs_waitrequest_out ##1 avs_waitrequest_out)
        else $error("bus answer not in one wait cycle");
endmodule

/* File: tfac_params.svh */
// offsets, field positions, reset values and sizes of the action comparator
// assumes inclusion by the comparator package, module and testbench only
`ifndef TFAC_PARAMS_SVH
`define TFAC_PARAMS_SVH
`define TFAC_FLOWS      8
`define TFAC_FW         3
`define TFAC_AW         9
`define TFAC_HDR_BYTES  32
`define TFAC_OFS_MASK_LO 9'h000
`define TFAC_OFS_MASK_HI 9'h004
`define TFAC_OFS_ASYM   9'h008
`define TFAC_OFS_STAT   9'h00c
`define TFAC_FLOW_FIRST 4'h2
`define TFAC_FLOW_LAST  4'h9
`define TFAC_W_PAT_LO   3'h0
`define TFAC_W_PAT_HI   3'h1
`define TFAC_W_RANGE    3'h2
`define TFAC_W_ACTION   3'h3
`define TFAC_W_LOC      3'h4
`define TFAC_RNG_LO     7:0
`define TFAC_RNG_HI     15:8
`define TFAC_RNG_EN     16
`define TFAC_RNG_OFS    28:24
`define TFAC_ACT_CMD    3:0
`define TFAC_ACT_SAVE   4
`define TFAC_ACT_ASADD  5
`define TFAC_ACT_ASSUB  6
`define TFAC_ACT_FLOWEN 7
`define TFAC_LOC_CF     4:0
`define TFAC_LOC_TS     13:8
`define TFAC_LOC_ZOFS   21:16
`define TFAC_LOC_ZLEN   27:24
`define TFAC_RST_WORD   32'h0000_0000
`endif

/* File: tfac_pkg.sv */
// types shared by the timing frame action comparator
// assumes tfac_params.svh is on the include path
`include "tfac_params.svh"
package tfac_pkg;
    typedef enum logic [3:0] {
        cmd_idle                       = 4'h0,
        cmd_cf_minus_time              = 4'h1,
        cmd_cf_minus_latency_plus_path = 4'h2,
        cmd_cf_plus_time               = 4'h3,
        cmd_cf_time_latency_storage    = 4'h4,
        cmd_store_time                 = 4'h5,
        cmd_store_time_path_legacy     = 4'h6,
        cmd_store_nanoseconds          = 4'h7,
        cmd_store_nanoseconds_peer     = 4'h8
    } tfac_cmd_e;

    typedef struct packed {
        logic                  valid;
        logic                  hit;
        logic [`TFAC_FW-1:0]   flow;
        logic [3:0]            cmd;
        logic                  cf_wr;
        logic                  ts_wr;
        logic                  nf_wr;
        logic [4:0]            cf_loc;
        logic [5:0]            ts_loc;
        logic [5:0]            zero_loc;
        logic [3:0]            zero_len;
        logic                  zero_en;
    } tfac_action_s;

    typedef struct packed {
        logic [63:0] cf;
        logic [63:0] ts;
        logic [63:0] nf;
        logic [63:0] active_ts;
    } tfac_values_s;
endpackage

/* File: tfac_upstream_model.sv */
// upstream comparator stage model: presents one header per request
// assumes the bench raises go_in for one cycle per header on mclk
`timescale 1ns/1ps
module tfac_upstream_model (
    input  wire logic         clk_in,        // system clock
    input  wire logic         rst_in,        // sync reset, high
    input  wire logic         go_in,         // present header next cycle
    input  wire logic [255:0] hdr_req_in,    // header to present
    input  wire logic [7:0]   prior_req_in,  // prior stage hits
    output logic              hdr_valid_out, // header valid
    output logic [255:0]      hdr_out,       // header bytes
    output logic [7:0]        prior_out      // prior hits
);
    // between frames the lines toggle, so stale bytes never look valid
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            hdr_valid_out <= 1'b0;
            hdr_out       <= '0;
            prior_out     <= '0;
        end else begin
            hdr_valid_out <= go_in;
            hdr_out       <= go_in ? hdr_req_in : ~hdr_out;
            prior_out     <= go_in ? prior_req_in : ~prior_out;
        end
    end
endmodule

/* File: tb_timing_frame_action_comparator.sv */
// self-checking bench of the action comparator
// assumes tfac_pkg compiled first and tfac_params.svh on the include path
`timescale 1ns/1ps
`include "tfac_params.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module tb_timing_frame_action_comparator;
    logic                   mclk_in, sys_rst_in, avs_read_in, avs_write_in, egress_in, go;
    logic                   avs_waitrequest_out, hdr_valid_in, fifo_push_out;
    logic [8:0]             avs_address_in;
    logic [31:0]            avs_writedata_in, avs_readdata_out, rd, seed, w, loc;
    logic [3:0]             avs_byteenable_in;
    logic [255:0]           hdr_in, hdr_req, h;
    logic [7:0]             prior_match_in, prior_req;
    logic [63:0]            cur_cf_in, stored_time_in, local_time_in, local_ns_in;
    logic [63:0]            latency_in, path_delay_in, fifo_time_out, asym, p;
    tfac_pkg::tfac_action_s action_out;
    tfac_pkg::tfac_values_s values_out;
    int                     fail_count, comparisons;

    tfac_comparator uut (
        .mclk_in, .sys_rst_in, .avs_address_in, .avs_read_in, .avs_write_in,
        .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
        .hdr_valid_in, .hdr_in, .prior_match_in, .egress_in, .cur_cf_in, .stored_time_in,
        .local_time_in, .local_ns_in, .latency_in, .path_delay_in, .action_out,
        .values_out, .fifo_push_out, .fifo_time_out
    );
    tfac_upstream_model partner (
        .clk_in(mclk_in), .rst_in(sys_rst_in), .go_in(go), .hdr_req_in(hdr_req),
        .prior_req_in(prior_req), .hdr_valid_out(hdr_valid_in), .hdr_out(hdr_in),
        .prior_out(prior_match_in)
    );

    initial begin
        mclk_in = 1'b0;
        forever #2 mclk_in = ~mclk_in;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [63:0] pat_of(input logic [255:0] hv);
        for (int k = 0; k < 8; k++) pat_of[63-8*k -: 8] = hv[8*k +: 8];
    endfunction

    function automatic logic [63:0] exp_cf(input logic [3:0] c, input logic ad, input logic sb);
        logic [63:0] v;
        case (c)
            4'h1: v = cur_cf_in - local_time_in;
            4'h2: v = cur_cf_in - latency_in + path_delay_in;
            4'h3: v = cur_cf_in + local_time_in;
            4'h4: v = cur_cf_in + local_time_in + latency_in - stored_time_in;
            4'h6: v = path_delay_in;
            4'h8: v = local_ns_in + path_delay_in;
            default: v = cur_cf_in;
        endcase
        if (c != 4'h0 && ad) v = v + asym;
        if (c != 4'h0 && sb) v = v - asym;
        return v;
    endfunction

    // request is held until the edge at which waitrequest is seen low
    task automatic bus(input logic wr, input logic [8:0] a, input logic [31:0] d);
        logic done;
        done = 1'b0;
        @(posedge mclk_in);
        avs_address_in   <= a;
        avs_writedata_in <= d;
        avs_write_in     <= wr;
        avs_read_in      <= !wr;
        while (!done) begin
            @(posedge mclk_in);
            if (avs_waitrequest_out === 1'b0) begin
                done = 1'b1;
                rd   = avs_readdata_out;
            end
        end
        avs_write_in <= 1'b0;
        avs_read_in  <= 1'b0;
    endtask

    task automatic cfg(input int f, input logic [63:0] pv, input logic [31:0] rng, act, lc);
        logic [8:0] b;
        b = 9'h040 + 9'(f) * 9'h020;
        bus(1'b1, b, pv[31:0]);
        bus(1'b1, b + 9'h004, pv[63:32]);
        bus(1'b1, b + 9'h008, rng);
        bus(1'b1, b + 9'h00c, act);
        bus(1'b1, b + 9'h010, lc);
    endtask

    task automatic send(input logic [255:0] hv, input logic [7:0] pm);
        @(posedge mclk_in);
        hdr_req        <= hv;
        prior_req      <= pm;
        go             <= 1'b1;
        cur_cf_in      <= {rnd(), rnd()};
        stored_time_in <= {rnd(), rnd()};
        local_time_in  <= {rnd(), rnd()};
        local_ns_in    <= {rnd(), rnd()};
        latency_in     <= {rnd(), rnd()};
        path_delay_in  <= {rnd(), rnd()};
        @(posedge mclk_in);
        go <= 1'b0;
        @(posedge mclk_in);
        @(negedge mclk_in);
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge mclk_in);
        fail_count++;
        $display("[ERR] %0t watchdog expired", $time);
        stop_test();
    end

    initial begin
        {avs_read_in, avs_write_in, go, egress_in} = 4'h0;
        {avs_address_in, avs_writedata_in, hdr_req, prior_req} = '0;
        {cur_cf_in, stored_time_in, local_time_in, local_ns_in, latency_in, path_delay_in} = '0;
        avs_byteenable_in = 4'hf;
        seed = 32'hab53;
        sys_rst_in = 1'b1;
        repeat (10) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        bus(1'b0, 9'h04c, 32'h0);
        `CHK(rd, 32'h0)
        bus(1'b0, 9'h1fc, 32'h0);
        `CHK(rd, 32'h0)
        bus(1'b1, 9'h000, 32'hffff_ffff);
        bus(1'b1, 9'h004, 32'hffff_ffff);
        bus(1'b0, 9'h004, 32'h0);
        `CHK(rd, 32'hffff_ffff)
        w = rnd();
        asym = {{32{w[31]}}, w};
        bus(1'b1, 9'h008, w);
        $display("registers done");
        for (int c = 0; c < 9; c++) begin
            for (int k = 0; k < 8; k++) h[32*k +: 32] = rnd();
            loc = rnd() & (c == 0 ? 32'h003f_3f1f : 32'h0f3f_3f1f);
            cfg(0, pat_of(h), 32'h0, {24'h0, 1'b1, c[3], c[2], 1'b0, c[3:0]}, loc);
            send(h, 8'h01);
            `CHK(action_out.hit, 1'b1)
            `CHK(action_out.cmd, c[3:0])
            `CHK(values_out.cf, exp_cf(c[3:0], c[2], c[3]))
            `CHK(values_out.ts, c == 5 ? local_time_in : c == 6 ? path_delay_in : stored_time_in)
            `CHK(values_out.nf, c == 7 ? local_ns_in : c == 8 ? local_ns_in + path_delay_in : 64'h0)
            `CHK(values_out.active_ts, c == 6 ? local_time_in : 64'h0)
            `CHK(action_out.cf_loc, loc[4:0])
            `CHK(action_out.ts_loc, loc[13:8])
            `CHK(action_out.zero_loc, loc[21:16])
            `CHK(action_out.zero_en, loc[27:24] != 4'h0)
        end
        bus(1'b0, 9'h00c, 32'h0);
        `CHK(rd, 32'h0009_0000)
        $display("commands done");
        p = pat_of(h);
        cfg(0, p, 32'h0, 32'h0000_0003, 32'h0);
        cfg(1, p ^ 64'h0000_00ff, 32'h0, 32'h0000_0085, 32'h0);
        bus(1'b1, 9'h000, 32'h0);
        send(h, 8'h03);
        `CHK(action_out.hit, 1'b1)
        `CHK(action_out.flow, 3'd1)
        send(h, 8'h01);
        `CHK(action_out.hit, 1'b0)
        `CHK(action_out.cmd, 4'h0)
        bus(1'b1, 9'h000, 32'hffff_ffff);
        send(h, 8'h02);
        `CHK(action_out.hit, 1'b0)
        $display("mask and flows done");
        cfg(1, p, 32'h0901_4020, 32'h0000_0085, 32'h0);
        for (int i = 0; i < 4; i++) begin
            h[79:72] = i[0] ? (i[1] ? 8'h41 : 8'h40) : (i[1] ? 8'h1f : 8'h20);
            send(h, 8'h02);
            `CHK(action_out.hit, !i[1])
        end
        $display("range done");
        h[79:72] = 8'h30;
        cfg(1, p, 32'h0901_4020, 32'h0000_0095, 32'h0);
        egress_in <= 1'b1;
        send(h, 8'h02);
        `CHK(fifo_push_out, 1'b1)
        `CHK(fifo_time_out, local_time_in)
        @(posedge mclk_in) egress_in <= 1'b0;
        send(h, 8'h02);
        `CHK(fifo_push_out, 1'b0)
        $display("save time done");
        stop_test();
    end
endmodule
